/* rtl/dmb_pkg.sv */
package dmb_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned BANK_W = 4;
   localparam int unsigned OFS_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NUM_BANKS = 16;
   localparam int unsigned CLK_PERIOD_NS = 8;

   // Access-bank split and the two banks it draws on
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] ACC_LOW_BANK = 4'h0;
   localparam logic [3:0] ACC_HIGH_BANK = 4'hF;

   // Memory regions and fixed locations
   localparam logic [11:0] SFR_ACC_BASE = 12'hF40;
   localparam logic [11:0] SFR_NONACC_BASE = 12'hEB0;
   localparam logic [11:0] ADDR_BANK_POINTER = 12'hFE0;
   localparam logic [11:0] ADDR_PC_LOW = 12'hFF9;
   localparam int unsigned GPR_DEPTH = 3760;

   // One bit per bank, set where the bank exists
   localparam logic [15:0] BANK_IMPL_MASK = 16'hFFFF;
   localparam logic [3:0] BANK_POINTER_RST = 4'h0;
   localparam logic [3:0] BANK_POINTER_UPPER = 4'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;

   typedef enum logic [3:0] {
      DMB_Q1 = 4'h1,
      DMB_Q2 = 4'h2,
      DMB_Q3 = 4'h4,
      DMB_Q4 = 4'h8
   } dmb_phase_t;

   typedef struct packed {
      logic valid;
      logic full_move;
      logic access_sel;
      logic [7:0] offset;
      logic [11:0] src_addr;
      logic [11:0] dst_addr;
      logic rd_en;
      logic wr_en;
      logic upd_flags;
      logic load_bank;
      logic [3:0] literal;
   } dmb_op_t;

endpackage

/* rtl/dmb_gpr_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module dmb_gpr_ram
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [11:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [11:0] raddr_i,
   output logic [7:0] rdata_o
);

   logic [7:0] mem_r [dmb_pkg::GPR_DEPTH];

   wire logic rin = raddr_i < dmb_pkg::SFR_NONACC_BASE;
   wire logic win = waddr_i < dmb_pkg::SFR_NONACC_BASE;

   assign rdata_o = rin ? mem_r[raddr_i] : dmb_pkg::READ_ZERO;

   // Contents carry no reset and survive every reset
   always_ff @(posedge clk_i)
   begin
      if (we_i && win)
      begin
         mem_r[waddr_i] <= wdata_i;
      end
   end

endmodule
`default_nettype wire

/* rtl/dmb_data_memory.sv */
// Function
// - Data memory is 16 banks of 256 bytes; address is bank above offset.
// - Bank pointer keeps only bits 3..0; they form the banked upper address.
// - Bank pointer upper four bits read zero and ignore writes.
// - A load-bank instruction loads the bank pointer from a literal.
// - Writes to missing banks are dropped; reads from them return zero.
// - Status flags update even when the target bank is missing.
// - Full-address move uses two 12-bit addresses, ignoring the bank pointer.
// - Access map: 00h-5Fh to bank 0, 60h-FFh to bank 15.
// - Access-select 1 forms address from bank pointer and offset.
// - Access-select 0 uses the access map and ignores the bank pointer.
// - Access-map accesses finish in one instruction cycle, no pointer update.
// - Access map as given holds only while extended set is off.
// - General RAM is not cleared by any reset.
// - Special registers fill EB0h-FFFh, top of bank 14 and all of bank 15; RAM grows from zero.
// - Unused special register locations read as zero.
// - Write to offset F9h in bank 0Fh hits the program counter low byte.
// - All sixteen banks are implemented.
// - Operand read in quarter two, destination write in quarter four.
`timescale 1ns/1ps
`default_nettype none
module dmb_data_memory
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire dmb_pkg::dmb_op_t op_i,
   input wire logic [7:0] alu_wdata_i,
   input wire logic extended_set_enable_i,
   input wire logic [7:0] sfr_rdata_i,
   input wire logic sfr_hit_i,
   output logic [3:0] phase_o,
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output logic flags_update_o,
   output logic [11:0] sfr_addr_o,
   output logic sfr_re_o,
   output logic sfr_we_o,
   output logic [7:0] sfr_wdata_o,
   output logic pc_low_write_o,
   output logic [7:0] bank_pointer_o
);

   function automatic logic [11:0] map_addr(input logic acc_sel, input logic [7:0] ofs,
                                            input logic [3:0] bp);
      logic [11:0] a;
      a = {bp, ofs};
      if (!acc_sel)
      begin
         // Access map never looks at the pointer, so it needs no prior update
         if (ofs < dmb_pkg::ACC_SPLIT)
            a = {dmb_pkg::ACC_LOW_BANK, ofs};
         else
            a = {dmb_pkg::ACC_HIGH_BANK, ofs};
      end
      return a;
   endfunction

   function automatic logic bank_ok(input logic [11:0] a);
      return dmb_pkg::BANK_IMPL_MASK[a[11:8]];
   endfunction

   function automatic logic in_sfr(input logic [11:0] a);
      return (a >= dmb_pkg::SFR_NONACC_BASE) && (a != dmb_pkg::ADDR_BANK_POINTER);
   endfunction

   dmb_pkg::dmb_phase_t phase_r;
   dmb_pkg::dmb_op_t op_r;
   logic [11:0] raddr_r;
   logic [11:0] waddr_r;
   logic [3:0] bp_r;
   logic [7:0] rdata_r;
   logic rdata_valid_r;
   logic flags_r;
   logic [11:0] sfr_addr_r;
   logic sfr_re_r;
   logic sfr_we_r;
   logic [7:0] wdata_r;
   logic pc_low_r;

   wire logic q1 = phase_r == dmb_pkg::DMB_Q1;
   wire logic q2 = phase_r == dmb_pkg::DMB_Q2;
   wire logic q3 = phase_r == dmb_pkg::DMB_Q3;
   wire logic q4 = phase_r == dmb_pkg::DMB_Q4;

   // Indexed-literal mapping with the extended set on is resolved upstream; the
   // core then hands in offsets that are read through the bank pointer, so this map is used only while it is off
   wire logic use_acc_map = !extended_set_enable_i;
   wire logic eff_sel = op_i.access_sel || !use_acc_map;
   wire logic [11:0] op_addr = map_addr(eff_sel, op_i.offset, bp_r);
   wire logic [11:0] raddr_nxt = op_i.full_move ? op_i.src_addr : op_addr;
   wire logic [11:0] waddr_nxt = op_i.full_move ? op_i.dst_addr : op_addr;

   wire logic rd_go = op_r.valid && op_r.rd_en;
   wire logic wr_go = op_r.valid && op_r.wr_en;
   wire logic [7:0] ram_rdata;
   wire logic ram_we = q4 && wr_go && bank_ok(waddr_r) &&
                       (waddr_r < dmb_pkg::SFR_NONACC_BASE);

   wire logic [7:0] bp_read = {dmb_pkg::BANK_POINTER_UPPER, bp_r};
   wire logic [7:0] sfr_read = sfr_hit_i ? sfr_rdata_i : dmb_pkg::READ_ZERO;
   wire logic [7:0] rdata_nxt =
      (!rd_go || !bank_ok(raddr_r)) ? dmb_pkg::READ_ZERO :
      (raddr_r == dmb_pkg::ADDR_BANK_POINTER) ? bp_read :
      in_sfr(raddr_r) ? sfr_read :
      ram_rdata;

   wire logic wdata_sel_move = op_r.full_move;
   wire logic [7:0] wdata_nxt = wdata_sel_move ? rdata_r : alu_wdata_i;
   wire logic sfr_we_nxt = wr_go && bank_ok(waddr_r) && in_sfr(waddr_r);
   wire logic bp_wr = q4 && wr_go && (waddr_r == dmb_pkg::ADDR_BANK_POINTER);
   wire logic bp_lit = q4 && op_r.valid && op_r.load_bank;

   dmb_gpr_ram u_ram
   (
      .clk_i(clk_i),
      .we_i(ram_we),
      .waddr_i(waddr_r),
      .wdata_i(wdata_r),
      .raddr_i(raddr_r),
      .rdata_o(ram_rdata)
   );

   // Quarter-cycle sequencer, one clock per quarter
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         phase_r <= dmb_pkg::DMB_Q1;
      else
         case (phase_r)
            dmb_pkg::DMB_Q1: phase_r <= dmb_pkg::DMB_Q2;
            dmb_pkg::DMB_Q2: phase_r <= dmb_pkg::DMB_Q3;
            dmb_pkg::DMB_Q3: phase_r <= dmb_pkg::DMB_Q4;
            dmb_pkg::DMB_Q4: phase_r <= dmb_pkg::DMB_Q1;
            default: phase_r <= dmb_pkg::DMB_Q1;
         endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         op_r <= '0;
         raddr_r <= 12'h000;
         waddr_r <= 12'h000;
      end
      else if (q1)
      begin
         op_r <= op_i;
         raddr_r <= raddr_nxt;
         waddr_r <= waddr_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         bp_r <= dmb_pkg::BANK_POINTER_RST;
      else if (bp_lit)
         bp_r <= op_r.literal;
      else if (bp_wr)
         bp_r <= wdata_r[3:0];
   end

   // Operand captured at the end of quarter two
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rdata_r <= 8'h00;
         rdata_valid_r <= 1'b0;
      end
      else
      begin
         rdata_valid_r <= q2 && rd_go;
         if (q2)
            rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sfr_addr_r <= 12'h000;
         sfr_re_r <= 1'b0;
         sfr_we_r <= 1'b0;
         wdata_r <= 8'h00;
         pc_low_r <= 1'b0;
         flags_r <= 1'b0;
      end
      else
      begin
         sfr_re_r <= q1 && op_i.valid && op_i.rd_en && bank_ok(raddr_nxt) && in_sfr(raddr_nxt);
         sfr_we_r <= q3 && sfr_we_nxt;
         pc_low_r <= q3 && sfr_we_nxt && (waddr_r == dmb_pkg::ADDR_PC_LOW);
         flags_r <= q3 && op_r.valid && op_r.upd_flags;
         if (q1)
            sfr_addr_r <= raddr_nxt;
         else if (q3)
            sfr_addr_r <= waddr_r;
         if (q3)
            wdata_r <= wdata_nxt;
      end
   end

   assign phase_o = phase_r;
   assign rdata_o = rdata_r;
   assign rdata_valid_o = rdata_valid_r;
   assign flags_update_o = flags_r;
   assign sfr_addr_o = sfr_addr_r;
   assign sfr_re_o = sfr_re_r;
   assign sfr_we_o = sfr_we_r;
   assign sfr_wdata_o = wdata_r;
   assign pc_low_write_o = pc_low_r;
   assign bank_pointer_o = bp_read;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   phase_order_a: assert property ($onehot(phase_o))
      else $error("quarter code not one-hot");

   phase_step_a: assert property (q4 |=> q1)
      else $error("quarter sequence broken");

   bp_upper_zero_a: assert property (bank_pointer_o[7:4] == 4'h0)
      else $error("bank pointer upper bits not zero");

   acc_low_map_a: assert property (q1 && !extended_set_enable_i && !op_i.full_move &&
      !op_i.access_sel && op_i.offset < 8'h60 |=> raddr_r == {4'h0, $past(op_i.offset)})
      else $error("access map low half wrong");

   acc_high_map_a: assert property (q1 && !extended_set_enable_i && !op_i.full_move &&
      !op_i.access_sel && op_i.offset >= 8'h60 |=> raddr_r == {4'hF, $past(op_i.offset)})
      else $error("access map high half wrong");

   banked_addr_a: assert property (q1 && !op_i.full_move && op_i.access_sel
      |=> waddr_r == {$past(bank_pointer_o[3:0]), $past(op_i.offset)})
      else $error("banked address wrong");

   full_move_a: assert property (q1 && op_i.full_move
      |=> raddr_r == $past(op_i.src_addr) && waddr_r == $past(op_i.dst_addr))
      else $error("full move address wrong");

   load_bank_a: assert property (q4 && op_r.valid && op_r.load_bank
      |=> bank_pointer_o == {4'h0, $past(op_r.literal)})
      else $error("bank literal not loaded");

   read_q2_a: assert property (rdata_valid_o |-> $past(q2) && q3)
      else $error("operand valid outside quarter three");

   sfr_zero_a: assert property (q2 && sfr_re_o && !sfr_hit_i && rd_go
      |=> rdata_o == 8'h00)
      else $error("unused special location not zero");

   pc_low_a: assert property (pc_low_write_o |-> sfr_we_o && sfr_addr_o == 12'hFF9 && q4)
      else $error("pc low strobe mismatch");

   flags_a: assert property (q3 && op_r.valid && op_r.upd_flags
      |=> flags_update_o ##1 !flags_update_o)
      else $error("flag update pulse missing");

   sfr_we_space_a: assert property (sfr_we_o |-> q4 && sfr_addr_o >= 12'hEB0 &&
      sfr_addr_o != 12'hFE0)
      else $error("special write outside special space");

   sfr_re_q2_a: assert property (sfr_re_o |-> q2 && sfr_addr_o >= 12'hEB0 &&
      sfr_addr_o != 12'hFE0)
      else $error("special read outside quarter two");

   ram_region_a: assert property (ram_we |-> q4 && waddr_r < 12'hEB0)
      else $error("general RAM written outside its region");

   bp_write_a: assert property (bp_wr && !bp_lit
      |=> bank_pointer_o == {4'h0, $past(sfr_wdata_o[3:0])})
      else $error("bank pointer write lost");

   move_data_a: assert property (q3 && op_r.valid && op_r.full_move
      |=> sfr_wdata_o == $past(rdata_o))
      else $error("move data not the source byte");

   rdata_hold_a: assert property (!q2 |=> $stable(rdata_o))
      else $error("operand changed outside quarter two");

   bp_hold_a: assert property (!(q4 && op_r.valid && (op_r.load_bank || op_r.wr_en))
      |=> $stable(bank_pointer_o))
      else $error("bank pointer changed without a load");

   flags_q4_a: assert property (flags_update_o |-> q4)
      else $error("flag pulse outside quarter four");

   banked_cov_c: cover property (q1 && op_i.valid && op_i.access_sel && !op_i.full_move);
   access_cov_c: cover property (q1 && op_i.valid && !op_i.access_sel && op_i.offset >= 8'h60);
   move_cov_c: cover property (q1 && op_i.valid && op_i.full_move ##3 ram_we);
   pc_cov_c: cover property (pc_low_write_o);
   bpwr_cov_c: cover property (bp_wr);

endmodule
`default_nettype wire

/* testbench/dmb_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dmb_core_model
(
   input wire logic clk_i,
   input wire logic [3:0] phase_i,
   input wire logic [11:0] sfr_addr_i,
   output var dmb_pkg::dmb_op_t op_o,
   output logic [7:0] alu_wdata_o,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o
);
   // Empty slots F60h..F65h answer with no hit and a junk byte
   assign sfr_hit_o = !(sfr_addr_i >= 12'hF60 && sfr_addr_i <= 12'hF65);
   assign sfr_rdata_o = sfr_hit_o ? (sfr_addr_i[7:0] ^ 8'hA5) : 8'h5A;
   initial
   begin
      op_o = '0;
      alu_wdata_o = 8'h00;
   end
   // Op held through Q1, ALU byte held through Q3, then scrambled
   task automatic issue(input dmb_pkg::dmb_op_t op, input logic [7:0] wdata);
      do @(posedge clk_i); while (phase_i !== 4'h8);
      op_o <= op;
      @(posedge clk_i);
      op_o <= '0;
      @(posedge clk_i);
      alu_wdata_o <= wdata;
      @(posedge clk_i);
      alu_wdata_o <= ~wdata;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i;
   logic resetn_i;
   logic extended_set_enable_i;
   dmb_pkg::dmb_op_t op_i;
   logic [7:0] alu_wdata_i, sfr_rdata_i, rdata_o, sfr_wdata_o, bank_pointer_o, c_wdata;
   logic sfr_hit_i, rdata_valid_o, flags_update_o, sfr_re_o, sfr_we_o, pc_low_write_o;
   logic [3:0] phase_o;
   logic [11:0] sfr_addr_o, c_raddr, c_waddr;
   logic c_re, c_rv, c_flags, c_we, c_pcl;
   int n_mismatch = 0;
   int n_tests = 0;

   dmb_data_memory DUT (.clk_i, .resetn_i, .op_i, .alu_wdata_i, .extended_set_enable_i,
      .sfr_rdata_i, .sfr_hit_i, .phase_o, .rdata_o, .rdata_valid_o, .flags_update_o,
      .sfr_addr_o, .sfr_re_o, .sfr_we_o, .sfr_wdata_o, .pc_low_write_o, .bank_pointer_o);

   dmb_core_model u_core (.clk_i(clk_i), .phase_i(phase_o), .sfr_addr_i(sfr_addr_o),
      .op_o(op_i), .alu_wdata_o(alu_wdata_i), .sfr_rdata_o(sfr_rdata_i), .sfr_hit_o(sfr_hit_i));

   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Pulses are caught in the quarter where they stand
   always @(posedge clk_i)
   begin
      if (phase_o === 4'h2) {c_re, c_raddr} <= {sfr_re_o, sfr_addr_o};
      if (phase_o === 4'h4) c_rv <= rdata_valid_o;
      if (phase_o === 4'h8) {c_flags, c_we, c_pcl, c_waddr, c_wdata} <=
         {flags_update_o, sfr_we_o, pc_low_write_o, sfr_addr_o, sfr_wdata_o};
   end

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp)
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      if (got !== exp)
         n_mismatch++;
   endtask

   function automatic dmb_pkg::dmb_op_t mk(input logic a, input logic [7:0] ofs,
                                         input logic rd, input logic wr, input logic [3:0] lit);
      mk = '{valid: 1'b1, access_sel: a, offset: ofs, rd_en: rd, wr_en: wr, upd_flags: 1'b1,
             load_bank: (lit != 4'h0), literal: lit, default: '0};
   endfunction

   task automatic exec(input dmb_pkg::dmb_op_t o, input logic [7:0] w);
      u_core.issue(o, w);
      #1;
   endtask

   task automatic do_reset;
      @(posedge clk_i) resetn_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
   endtask

   task automatic t_access_low;
      exec(mk(1'b0, 8'h10, 1'b0, 1'b1, 4'h0), 8'h3C);
      chk("flags", 12'h1, {11'h0, c_flags});
      exec(mk(1'b1, 8'h10, 1'b1, 1'b0, 4'h0), 8'h00);
      chk("rdata", 12'h03C, {4'h0, rdata_o});
      chk("rvalid", 12'h1, {11'h0, c_rv});
      chk("sfr_re", 12'h0, {11'h0, c_re});
   endtask

   task automatic t_bank_literal;
      exec(mk(1'b0, 8'h00, 1'b0, 1'b0, 4'hF), 8'h00);
      chk("bank_pointer", 12'h00F, {4'h0, bank_pointer_o});
      exec(mk(1'b0, 8'h10, 1'b1, 1'b0, 4'h0), 8'h00);
      chk("rdata", 12'h03C, {4'h0, rdata_o});
      exec(mk(1'b1, 8'h10, 1'b1, 1'b0, 4'h0), 8'h00);
      chk("raddr", 12'hF10, c_raddr);
      chk("sfr_re", 12'h1, {11'h0, c_re});
      chk("rdata", 12'h0B5, {4'h0, rdata_o});
   endtask

   task automatic t_pc_low;
      exec(mk(1'b1, 8'hF9, 1'b0, 1'b1, 4'h0), 8'h77);
      chk("pc_low", 12'h1, {11'h0, c_pcl});
      chk("sfr_we", 12'h1, {11'h0, c_we});
      chk("waddr", 12'hFF9, c_waddr);
      chk("wdata", 12'h077, {4'h0, c_wdata});
   endtask

   task automatic t_unused_sfr;
      exec(mk(1'b0, 8'h60, 1'b1, 1'b0, 4'h0), 8'h00);
      chk("raddr", 12'hF60, c_raddr);
      chk("sfr_re", 12'h1, {11'h0, c_re});
      chk("rdata", 12'h000, {4'h0, rdata_o});
      chk("flags", 12'h1, {11'h0, c_flags});
   endtask

   task automatic t_bp_write;
      exec(mk(1'b0, 8'hE0, 1'b0, 1'b1, 4'h0), 8'hA3);
      chk("sfr_we", 12'h0, {11'h0, c_we});
      chk("pc_low", 12'h0, {11'h0, c_pcl});
      chk("bank_pointer", 12'h003, {4'h0, bank_pointer_o});
      exec(mk(1'b0, 8'hE0, 1'b1, 1'b0, 4'h0), 8'h00);
      chk("rdata", 12'h003, {4'h0, rdata_o});
   endtask

   task automatic t_full_move;
      dmb_pkg::dmb_op_t o;
      o = mk(1'b0, 8'h00, 1'b1, 1'b1, 4'h0);
      o.full_move = 1'b1;
      o.src_addr = 12'h010;
      o.dst_addr = 12'h123;
      exec(o, 8'h00);
      exec(mk(1'b0, 8'h00, 1'b0, 1'b0, 4'h1), 8'h00);
      exec(mk(1'b1, 8'h23, 1'b1, 1'b0, 4'h0), 8'h00);
      chk("rdata", 12'h03C, {4'h0, rdata_o});
   endtask

   task automatic t_ext_set;
      @(posedge clk_i) extended_set_enable_i <= 1'b1;
      exec(mk(1'b0, 8'h23, 1'b1, 1'b0, 4'h0), 8'h00);
      chk("rdata", 12'h03C, {4'h0, rdata_o});
      @(posedge clk_i) extended_set_enable_i <= 1'b0;
   endtask

   task automatic t_reset_keeps;
      do_reset();
      #1;
      chk("bank_pointer", 12'h000, {4'h0, bank_pointer_o});
      exec(mk(1'b0, 8'h10, 1'b1, 1'b0, 4'h0), 8'h00);
      chk("rdata", 12'h03C, {4'h0, rdata_o});
   endtask

   initial
   begin
      repeat (2000) @(posedge clk_i);
      n_mismatch++;
      test_done();
   end

   initial
   begin
      resetn_i = 1'b0;
      extended_set_enable_i = 1'b0;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      #1;
      chk("bank_pointer", 12'h000, {4'h0, bank_pointer_o});
      t_access_low();
      t_bank_literal();
      t_pc_low();
      t_unused_sfr();
      t_bp_write();
      t_full_move();
      t_ext_set();
      t_reset_keeps();
      test_done();
   end
endmodule
`default_nettype wire
